//--- opc_cal_sync.sv
`timescale 1ns/100ps
// Purpose: calibration edge pulses and lock gated distribution sync
// Assumes: pllLockedPin asynchronous, syncRequest on clk
// Notes:   pulses last one cycle
module opc_cal_sync (
    input  wire logic clk,
    input  wire logic rst,
    opc_cfg_if.user   cfg,
    input  wire logic pllLockedPin,
    input  wire logic syncRequest,
    output logic      calResetPulse,
    output logic      calStartPulse,
    output logic      distSync,
    output logic      pllLocked
);
    logic lockMeta_reg;
    logic lock_reg;
    logic calRstOld_reg;
    logic calGoOld_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            lockMeta_reg <= 1'b0;
            lock_reg     <= 1'b0;
        end else begin
            lockMeta_reg <= pllLockedPin;
            lock_reg     <= lockMeta_reg;
        end
    end
    assign pllLocked = lock_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            calRstOld_reg <= 1'b0;
            calGoOld_reg  <= 1'b0;
            calResetPulse <= 1'b0;
            calStartPulse <= 1'b0;
        end else begin
            calRstOld_reg <= cfg.calResetBit;
            calGoOld_reg  <= cfg.calStartBit;
            calResetPulse <= cfg.calResetBit & ~calRstOld_reg;
            calStartPulse <= cfg.calStartBit & ~calGoOld_reg;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            distSync <= 1'b0;
        end else begin
            distSync <= syncRequest & (cfg.lockGated | lock_reg);
        end
    end
endmodule

//--- opc_cfg_if.sv
`timescale 1ns/100ps
// Purpose: carries configuration fields from the bank to its helpers
// Assumes: single clock domain
// Notes:   bank drives, helpers only read
interface opc_cfg_if;
    logic [7:0] cpCode;
    logic [1:0] pole2Sel;
    logic [2:0] zeroSel;
    logic [2:0] pole1Sel;
    logic       zeroBypass;
    logic       lockGated;
    logic       calResetBit;
    logic       calStartBit;

    modport bank (output cpCode, pole2Sel, zeroSel, pole1Sel, zeroBypass, lockGated,
                  calResetBit, calStartBit);
    modport user (input cpCode, pole2Sel, zeroSel, pole1Sel, zeroBypass, lockGated,
                  calResetBit, calStartBit);
endinterface

//--- opc_loop_decode.sv
`timescale 1ns/100ps
// Purpose: turns loop filter and pump codes into physical settings
// Assumes: fields held stable by the register bank
// Notes:   outputs registered
module opc_loop_decode (
    input  wire logic  clk,
    input  wire logic  rst,
    opc_cfg_if.user    cfg,
    output logic [19:0] cpCurrentNa,
    output logic [10:0] pole2Ohm,
    output logic [10:0] zeroOhm,
    output logic [6:0]  pole1Pf,
    output logic        zeroShorted
);
    function automatic logic [10:0] zeroTable(input logic [2:0] code);
        case (code)
            3'h0:    zeroTable = 11'h5dc;
            3'h1:    zeroTable = 11'h4e2;
            3'h2:    zeroTable = 11'h3e8;
            3'h3:    zeroTable = 11'h3a2;
            3'h4:    zeroTable = 11'h4e2;
            3'h5:    zeroTable = 11'h3e8;
            3'h6:    zeroTable = 11'h2ee;
            default: zeroTable = 11'h2a8;
        endcase
    endfunction

    function automatic logic [6:0] capTable(input logic [2:0] code);
        case (code)
            3'h0:    capTable = 7'h00;
            3'h1:    capTable = 7'h14;
            3'h2:    capTable = 7'h50;
            3'h3:    capTable = 7'h64;
            3'h4:    capTable = 7'h14;
            3'h5:    capTable = 7'h28;
            3'h6:    capTable = 7'h64;
            default: capTable = 7'h78;
        endcase
    endfunction

    always_ff @(posedge clk) begin
        if (rst) begin
            cpCurrentNa <= 20'h00000;
            pole2Ohm    <= 11'h000;
            zeroOhm     <= 11'h000;
            pole1Pf     <= 7'h00;
            zeroShorted <= 1'b0;
        end else begin
            cpCurrentNa <= 20'(cfg.cpCode) * opc_pkg::CP_STEP_NA;
            case (cfg.pole2Sel)
                2'h0:    pole2Ohm <= 11'h1f4;
                2'h1:    pole2Ohm <= 11'h14d;
                2'h2:    pole2Ohm <= 11'h0fa;
                default: pole2Ohm <= 11'h0c8;
            endcase
            zeroOhm     <= cfg.zeroBypass ? 11'h000 : zeroTable(cfg.zeroSel);
            pole1Pf     <= capTable(cfg.pole1Sel);
            zeroShorted <= cfg.zeroBypass;
        end
    end
endmodule

//--- opc_output_pll_regs.sv
// Chosen here: the APB register port.
`timescale 1ns/100ps
// Purpose: apb register bank configuring the output analog pll
// Assumes: apb master, zero wait states, 125 MHz clk
// Notes:   unmapped or misaligned access answers pslverr
//
// What this block does
// - pump current code counts 3.5 uA steps, resets to 0x81
// - pole2 resistor code 00..11 gives 500, 333, 250, 200 ohm
// - zero resistor code picks one of six values (eight codes), 000 is 1500 ohm
// - pole1 capacitor code picks one of six values (eight codes), default 111 is 120 pF
// - bypass bit shorts the internal zero resistor when set
// - sync waits for lock unless the override bit is set
// - calibration reset and start act on rising edges; start not self clearing
module opc_output_pll_regs (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [15:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        pllLockedPin,
    input  wire logic        syncRequest,
    output logic [7:0]       fbDivider,
    output logic             fbDividerValid,
    output logic [19:0]      cpCurrentNa,
    output logic [10:0]      pole2Ohm,
    output logic [10:0]      zeroOhm,
    output logic [6:0]       pole1Pf,
    output logic             zeroShorted,
    output logic             calResetPulse,
    output logic             calStartPulse,
    output logic             distSync
);
    logic [7:0]  cpCode_reg;
    logic [7:0]  fbDiv_reg;
    logic [7:0]  loopSel_reg;
    logic [7:0]  bypass_reg;
    logic [7:0]  calSync_reg;
    logic [31:0] rdata_reg;
    logic        fbValid_reg;
    logic        pllLocked;
    logic        hit;
    logic        wrEn;
    logic [13:0] idx;

    opc_cfg_if cfg ();

    function automatic logic mapped(input logic [15:0] a);
        logic [13:0] i;
        i      = a[15:2];
        mapped = (a[1:0] == 2'h0) && (i >= opc_pkg::IDX_CP_CURRENT)
                 && (i <= opc_pkg::IDX_CAL_SYNC);
    endfunction

    function automatic logic [7:0] readByte(input logic [13:0] i, input logic [7:0] cp,
                                            input logic [7:0] fb, input logic [7:0] lf,
                                            input logic [7:0] bp, input logic [7:0] cs);
        case (i)
            opc_pkg::IDX_CP_CURRENT: readByte = cp;
            opc_pkg::IDX_FB_DIVIDER: readByte = fb;
            opc_pkg::IDX_SPARE:      readByte = opc_pkg::RST_SPARE;
            opc_pkg::IDX_LOOP_SEL:   readByte = lf;
            opc_pkg::IDX_ZR_BYPASS:  readByte = bp;
            opc_pkg::IDX_CAL_SYNC:   readByte = cs;
            default:                 readByte = 8'h00;
        endcase
    endfunction

    assign idx     = paddr[15:2];
    assign hit     = mapped(paddr);
    assign wrEn    = psel & penable & pwrite & hit;
    assign pready  = psel & penable;
    assign pslverr = psel & penable & ~hit;

    always_ff @(posedge clk) begin
        if (rst) begin
            cpCode_reg <= opc_pkg::RST_CP_CURRENT;
        end else if (wrEn && idx == opc_pkg::IDX_CP_CURRENT) begin
            cpCode_reg <= pwdata[7:0];
        end
    end

    // feedback divider register
    always_ff @(posedge clk) begin
        if (rst) begin
            fbDiv_reg <= opc_pkg::RST_FB_DIVIDER;
        end else if (wrEn && idx == opc_pkg::IDX_FB_DIVIDER) begin
            fbDiv_reg <= pwdata[7:0];
        end
    end

    // loop filter selections
    always_ff @(posedge clk) begin
        if (rst) begin
            loopSel_reg <= opc_pkg::RST_LOOP_SEL;
        end else if (wrEn && idx == opc_pkg::IDX_LOOP_SEL) begin
            loopSel_reg <= pwdata[7:0];
        end
    end

    // bypass register, reserved bits hold
    always_ff @(posedge clk) begin
        if (rst) begin
            bypass_reg <= opc_pkg::RST_ZR_BYPASS;
        end else if (wrEn && idx == opc_pkg::IDX_ZR_BYPASS) begin
            bypass_reg <= (pwdata[7:0] & opc_pkg::MASK_ZR_BYPASS)
                          | (opc_pkg::RST_ZR_BYPASS & ~opc_pkg::MASK_ZR_BYPASS);
        end
    end

    // calibration and sync control, reserved bits hold
    always_ff @(posedge clk) begin
        if (rst) begin
            calSync_reg <= opc_pkg::RST_CAL_SYNC;
        end else if (wrEn && idx == opc_pkg::IDX_CAL_SYNC) begin
            calSync_reg <= (pwdata[7:0] & opc_pkg::MASK_CAL_SYNC)
                           | (opc_pkg::RST_CAL_SYNC & ~opc_pkg::MASK_CAL_SYNC);
        end
    end

    // read data captured in setup phase
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_reg <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            rdata_reg <= {24'h000000, readByte(idx, cpCode_reg, fbDiv_reg, loopSel_reg,
                                               bypass_reg, calSync_reg)};
        end
    end
    assign prdata = rdata_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            fbValid_reg <= 1'b1;
        end else begin
            fbValid_reg <= (fbDiv_reg >= opc_pkg::FB_DIV_MIN)
                           && (fbDiv_reg <= opc_pkg::FB_DIV_MAX);
        end
    end
    assign fbDivider      = fbDiv_reg;
    assign fbDividerValid = fbValid_reg;

    assign cfg.cpCode      = cpCode_reg;
    assign cfg.pole2Sel    = loopSel_reg[opc_pkg::P2_LSB +: 2];
    assign cfg.zeroSel     = loopSel_reg[opc_pkg::ZR_LSB +: 3];
    assign cfg.pole1Sel    = loopSel_reg[opc_pkg::C1_LSB +: 3];
    assign cfg.zeroBypass  = bypass_reg[opc_pkg::BYPASS_BIT];
    assign cfg.lockGated   = calSync_reg[opc_pkg::LOCKGT_BIT];
    assign cfg.calResetBit = calSync_reg[opc_pkg::CALRST_BIT];
    assign cfg.calStartBit = calSync_reg[opc_pkg::CALGO_BIT];

    opc_loop_decode uDecode (
        .clk         (clk),
        .rst         (rst),
        .cfg         (cfg),
        .cpCurrentNa (cpCurrentNa),
        .pole2Ohm    (pole2Ohm),
        .zeroOhm     (zeroOhm),
        .pole1Pf     (pole1Pf),
        .zeroShorted (zeroShorted)
    );

    opc_cal_sync uCal (
        .clk           (clk),
        .rst           (rst),
        .cfg           (cfg),
        .pllLockedPin  (pllLockedPin),
        .syncRequest   (syncRequest),
        .calResetPulse (calResetPulse),
        .calStartPulse (calStartPulse),
        .distSync      (distSync),
        .pllLocked     (pllLocked)
    );

    // checks
    property p_cp_scale;
        @(posedge clk) disable iff (rst)
        !rst |=> cpCurrentNa == 20'($past(cpCode_reg)) * opc_pkg::CP_STEP_NA;
    endproperty
    a_cp_scale: assert property (p_cp_scale) else $error("pump current mismatch");

    property p_cp_reset;
        @(posedge clk) $fell(rst) |-> cpCode_reg == opc_pkg::RST_CP_CURRENT;
    endproperty
    a_cp_reset: assert property (p_cp_reset) else $error("pump reset value wrong");

    property p_p2_decode;
        @(posedge clk) disable iff (rst)
        ##1 ($past(loopSel_reg[7:6]) == 2'h1) |-> pole2Ohm == 11'h14d;
    endproperty
    a_p2_decode: assert property (p_p2_decode) else $error("pole2 decode wrong");

    property p_zero_default;
        @(posedge clk) disable iff (rst)
        ##1 ($past(loopSel_reg[5:3]) == 3'h7 && !$past(bypass_reg[0])) |->
            zeroOhm == 11'h2a8;
    endproperty
    a_zero_default: assert property (p_zero_default) else $error("zero decode wrong");

    property p_cap_max;
        @(posedge clk) disable iff (rst)
        (!rst && loopSel_reg[2:0] == 3'h7) |=> pole1Pf == 7'h78;
    endproperty
    a_cap_max: assert property (p_cap_max) else $error("capacitor decode wrong");

    property p_bypass;
        @(posedge clk) disable iff (rst)
        bypass_reg[0] |=> zeroShorted && zeroOhm == 11'h000;
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass not applied");

    property p_sync_gate;
        @(posedge clk) disable iff (rst)
        (!calSync_reg[3] && !pllLocked) |=> !distSync;
    endproperty
    a_sync_gate: assert property (p_sync_gate) else $error("sync before lock");

    property p_cal_edge;
        @(posedge clk) disable iff (rst)
        $rose(calSync_reg[0]) |=> calStartPulse ##1 !calStartPulse;
    endproperty
    a_cal_edge: assert property (p_cal_edge) else $error("start pulse wrong");

    property p_div_valid;
        @(posedge clk) disable iff (rst)
        (fbDiv_reg > 8'h19) |=> !fbDividerValid;
    endproperty
    a_div_valid: assert property (p_div_valid) else $error("divider range wrong");

    property p_cp_write;
        @(posedge clk) disable iff (rst)
        (wrEn && idx == opc_pkg::IDX_CP_CURRENT) |=> cpCode_reg == $past(pwdata[7:0]);
    endproperty
    a_cp_write: assert property (p_cp_write) else $error("pump write lost");

    property p_cp_read;
        @(posedge clk) disable iff (rst)
        (psel && penable && !pwrite && hit && idx == opc_pkg::IDX_CP_CURRENT) |->
            prdata == {24'h000000, cpCode_reg};
    endproperty
    a_cp_read: assert property (p_cp_read) else $error("pump read wrong");

    property p_bad_write;
        @(posedge clk) disable iff (rst)
        (psel && penable && pwrite && !hit) |=>
            $stable(cpCode_reg) && $stable(fbDiv_reg) && $stable(loopSel_reg)
            && $stable(bypass_reg) && $stable(calSync_reg);
    endproperty
    a_bad_write: assert property (p_bad_write) else $error("refused write landed");

    property p_bypass_off;
        @(posedge clk) disable iff (rst)
        !bypass_reg[0] |=> !zeroShorted;
    endproperty
    a_bypass_off: assert property (p_bypass_off) else $error("bypass stuck");

    property p_sync_lock;
        @(posedge clk) disable iff (rst)
        (syncRequest && pllLocked) |=> distSync;
    endproperty
    a_sync_lock: assert property (p_sync_lock) else $error("sync missed at lock");

    property p_sync_override;
        @(posedge clk) disable iff (rst)
        (syncRequest && calSync_reg[3]) |=> distSync;
    endproperty
    a_sync_override: assert property (p_sync_override) else $error("override ignored");

    property p_sync_idle;
        @(posedge clk) disable iff (rst)
        !syncRequest |=> !distSync;
    endproperty
    a_sync_idle: assert property (p_sync_idle) else $error("sync without request");

    property p_cal_rst_edge;
        @(posedge clk) disable iff (rst)
        $rose(calSync_reg[1]) |=> calResetPulse ##1 !calResetPulse;
    endproperty
    a_cal_rst_edge: assert property (p_cal_rst_edge) else $error("reset pulse wrong");

    property p_no_start;
        @(posedge clk) disable iff (rst)
        !$rose(calSync_reg[0]) |=> !calStartPulse;
    endproperty
    a_no_start: assert property (p_no_start) else $error("spurious start pulse");

    property p_div_in;
        @(posedge clk) disable iff (rst)
        (fbDiv_reg >= opc_pkg::FB_DIV_MIN && fbDiv_reg <= opc_pkg::FB_DIV_MAX) |=>
            fbDividerValid;
    endproperty
    a_div_in: assert property (p_div_in) else $error("valid divider flagged");

    property p_div_low;
        @(posedge clk) disable iff (rst)
        (fbDiv_reg < opc_pkg::FB_DIV_MIN) |=> !fbDividerValid;
    endproperty
    a_div_low: assert property (p_div_low) else $error("low divider accepted");

    c_write: cover property (@(posedge clk) disable iff (rst) wrEn);
    c_err: cover property (@(posedge clk) disable iff (rst) pslverr);
    c_cal: cover property (@(posedge clk) disable iff (rst) calStartPulse);
    c_sync: cover property (@(posedge clk) disable iff (rst) distSync);
    c_cal_rst: cover property (@(posedge clk) disable iff (rst) calResetPulse);
endmodule

//--- opc_pkg.sv
// Purpose: shared constants for the output pll configuration bank
// Assumes: 32-bit apb data, one register per aligned word
// Notes:   register index times four gives the byte address
package opc_pkg;
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned DATA_W = 32;

    // register indices
    localparam logic [13:0] IDX_CP_CURRENT = 14'h0400;
    localparam logic [13:0] IDX_FB_DIVIDER = 14'h0401;
    localparam logic [13:0] IDX_SPARE      = 14'h0402;
    localparam logic [13:0] IDX_LOOP_SEL   = 14'h0403;
    localparam logic [13:0] IDX_ZR_BYPASS  = 14'h0404;
    localparam logic [13:0] IDX_CAL_SYNC   = 14'h0405;

    // reset values
    localparam logic [7:0] RST_CP_CURRENT = 8'h81;
    localparam logic [7:0] RST_FB_DIVIDER = 8'h14;
    localparam logic [7:0] RST_SPARE      = 8'h00;
    localparam logic [7:0] RST_LOOP_SEL   = 8'h07;
    localparam logic [7:0] RST_ZR_BYPASS  = 8'h00;
    localparam logic [7:0] RST_CAL_SYNC   = 8'h20;

    // field positions
    localparam int unsigned P2_LSB     = 6;
    localparam int unsigned ZR_LSB     = 3;
    localparam int unsigned C1_LSB     = 0;
    localparam int unsigned BYPASS_BIT = 0;
    localparam int unsigned LOCKGT_BIT = 3;
    localparam int unsigned CALRST_BIT = 1;
    localparam int unsigned CALGO_BIT  = 0;

    // writable bit masks
    localparam logic [7:0] MASK_ZR_BYPASS = 8'h01;
    localparam logic [7:0] MASK_CAL_SYNC  = 8'h0b;

    // analog scaling and valid divider range
    localparam logic [19:0] CP_STEP_NA = 20'h00dac;
    localparam logic [7:0]  FB_DIV_MIN = 8'h0e;
    localparam logic [7:0]  FB_DIV_MAX = 8'h19;
endpackage

//--- tb_top.sv
// Purpose: self-checking bench for the output pll configuration bank
// Assumes: zero wait apb slave, decoded outputs settle two edges after a write
// Notes:   byte address is register index times four
`timescale 1ns/100ps
module tb_top;
    logic        clk;
    logic        rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        pllLockedPin;
    logic        syncRequest;
    logic [7:0]  fbDivider;
    logic        fbDividerValid;
    logic [19:0] cpCurrentNa;
    logic [10:0] pole2Ohm;
    logic [10:0] zeroOhm;
    logic [6:0]  pole1Pf;
    logic        zeroShorted;
    logic        calResetPulse;
    logic        calStartPulse;
    logic        distSync;
    int          errTotal = 0;
    int          nChecks = 0;
    int          nStart = 0;
    int          nReset = 0;
    logic [31:0] rd;
    logic        er;
    logic [10:0] p2Tab [4] = '{11'h1f4, 11'h14d, 11'h0fa, 11'h0c8};
    logic [10:0] zrTab [8] = '{11'h5dc, 11'h4e2, 11'h3e8, 11'h3a2,
                               11'h4e2, 11'h3e8, 11'h2ee, 11'h2a8};
    logic [6:0]  c1Tab [8] = '{7'h00, 7'h14, 7'h50, 7'h64, 7'h14, 7'h28, 7'h64, 7'h78};

    opc_output_pll_regs opc_output_pll_regs_i (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pllLockedPin(pllLockedPin), .syncRequest(syncRequest),
        .fbDivider(fbDivider), .fbDividerValid(fbDividerValid),
        .cpCurrentNa(cpCurrentNa), .pole2Ohm(pole2Ohm), .zeroOhm(zeroOhm),
        .pole1Pf(pole1Pf), .zeroShorted(zeroShorted), .calResetPulse(calResetPulse),
        .calStartPulse(calStartPulse), .distSync(distSync)
    );

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // pulse cycle counters
    always @(posedge clk) begin
        if (calStartPulse === 1'b1) nStart <= nStart + 1;
        if (calResetPulse === 1'b1) nReset <= nReset + 1;
    end

    task automatic results();
        if (errTotal == 0 && nChecks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        nChecks++;
        if (got !== exp) begin
            errTotal++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
    endtask

    // one apb transfer, result left in rd and er
    task automatic apb(input logic wr, input logic [15:0] addr, input logic [7:0] wd);
        int n;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= {24'h000000, wd};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            errTotal++;
            $display("unexpected at %0t: no pready", $time);
            results();
        end
    endtask

    task automatic wr(input logic [13:0] idx, input logic [7:0] d);
        apb(1'b1, {idx, 2'b00}, d);
    endtask

    task automatic rdchk(input logic [13:0] idx, input logic [7:0] exp);
        apb(1'b0, {idx, 2'b00}, 8'h00);
        chk(rd, {24'h000000, exp}, "read data");
    endtask

    task automatic t_reset();
        rdchk(opc_pkg::IDX_CP_CURRENT, 8'h81);
        rdchk(opc_pkg::IDX_FB_DIVIDER, 8'h14);
        rdchk(opc_pkg::IDX_SPARE, 8'h00);
        rdchk(opc_pkg::IDX_LOOP_SEL, 8'h07);
        rdchk(opc_pkg::IDX_ZR_BYPASS, 8'h00);
        rdchk(opc_pkg::IDX_CAL_SYNC, 8'h20);
        chk(cpCurrentNa, 32'h00000081 * 32'h00000dac, "pump current");
        chk(pole2Ohm, p2Tab[0], "pole2");
        chk(zeroOhm, zrTab[0], "zero resistor");
        chk(pole1Pf, c1Tab[7], "pole1");
        chk(zeroShorted, 1'b0, "bypass");
    endtask

    task automatic t_pump();
        wr(opc_pkg::IDX_CP_CURRENT, 8'hff);
        cyc(3);
        chk(cpCurrentNa, 32'h000000ff * 32'h00000dac, "pump current");
        wr(opc_pkg::IDX_CP_CURRENT, 8'h00);
        cyc(3);
        chk(cpCurrentNa, 32'h00000000, "pump current");
    endtask

    task automatic t_div();
        logic [7:0] v [4] = '{8'h0d, 8'h0e, 8'h19, 8'h1a};
        for (int i = 0; i < 4; i++) begin
            wr(opc_pkg::IDX_FB_DIVIDER, v[i]);
            cyc(3);
            chk(fbDivider, v[i], "divider");
            chk(fbDividerValid, (v[i] >= 8'h0e && v[i] <= 8'h19), "divider valid");
        end
    endtask

    task automatic t_loop();
        for (int i = 0; i < 8; i++) begin
            wr(opc_pkg::IDX_LOOP_SEL, {i[1:0], i[2:0], i[2:0]});
            cyc(3);
            chk(pole2Ohm, p2Tab[i[1:0]], "pole2");
            chk(zeroOhm, zrTab[i], "zero resistor");
            chk(pole1Pf, c1Tab[i], "pole1");
        end
    endtask

    task automatic t_bypass();
        wr(opc_pkg::IDX_ZR_BYPASS, 8'hff);
        rdchk(opc_pkg::IDX_ZR_BYPASS, 8'h01);
        cyc(2);
        chk(zeroShorted, 1'b1, "bypass");
        chk(zeroOhm, 11'h000, "zero resistor");
        wr(opc_pkg::IDX_ZR_BYPASS, 8'h00);
        cyc(3);
        chk(zeroShorted, 1'b0, "bypass");
    endtask

    task automatic t_cal();
        wr(opc_pkg::IDX_CAL_SYNC, 8'h01);
        cyc(4);
        chk(nStart, 1, "start pulses");
        wr(opc_pkg::IDX_CAL_SYNC, 8'h01);
        cyc(4);
        chk(nStart, 1, "start pulses");
        wr(opc_pkg::IDX_CAL_SYNC, 8'h00);
        wr(opc_pkg::IDX_CAL_SYNC, 8'h01);
        cyc(4);
        chk(nStart, 2, "start pulses");
        wr(opc_pkg::IDX_CAL_SYNC, 8'h03);
        cyc(4);
        chk(nReset, 1, "reset pulses");
        chk(nStart, 2, "start pulses");
        wr(opc_pkg::IDX_CAL_SYNC, 8'hf4);
        rdchk(opc_pkg::IDX_CAL_SYNC, 8'h20);
    endtask

    task automatic t_sync();
        syncRequest  <= 1'b1;
        pllLockedPin <= 1'b0;
        cyc(6);
        chk(distSync, 1'b0, "sync held");
        pllLockedPin <= 1'b1;
        cyc(5);
        chk(distSync, 1'b1, "sync locked");
        syncRequest <= 1'b0;
        cyc(2);
        chk(distSync, 1'b0, "sync idle");
        pllLockedPin <= 1'b0;
        syncRequest  <= 1'b1;
        wr(opc_pkg::IDX_CAL_SYNC, 8'h08);
        cyc(3);
        chk(distSync, 1'b1, "sync override");
        rdchk(opc_pkg::IDX_CAL_SYNC, 8'h28);
        syncRequest <= 1'b0;
        cyc(2);
        chk(distSync, 1'b0, "sync idle");
    endtask

    task automatic t_err();
        apb(1'b0, 16'h1018, 8'h00);
        chk(er, 1'b1, "unmapped error");
        chk(rd, 32'h00000000, "unmapped data");
        apb(1'b1, 16'h1001, 8'h55);
        chk(er, 1'b1, "misaligned error");
        rdchk(opc_pkg::IDX_CP_CURRENT, 8'h00);
        chk(er, 1'b0, "mapped error");
        wr(opc_pkg::IDX_SPARE, 8'hff);
        rdchk(opc_pkg::IDX_SPARE, 8'h00);
    endtask

    initial begin
        rst          = 1'b1;
        psel         = 1'b0;
        penable      = 1'b0;
        pwrite       = 1'b0;
        paddr        = 16'h0000;
        pwdata       = 32'h00000000;
        pllLockedPin = 1'b0;
        syncRequest  = 1'b0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        cyc(2);
        t_reset();
        t_pump();
        t_div();
        t_loop();
        t_bypass();
        t_cal();
        t_sync();
        t_err();
        results();
    end
endmodule
